/* File: shared/abx_pkg.sv */
// abx_pkg: constants and carriers for the add/and/bit-set execute datapath
// assumes a 14-bit instruction word and an 8-bit working register
package abx_pkg;

  localparam int unsigned INSN_W  = 14;
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned FADDR_W = 7;
  localparam int unsigned BADDR_W = 6;
  localparam int unsigned BIDX_W  = 3;

  // opcode patterns, matched on the upper bits of the word
  localparam logic [5:0] OP_ADD_LIT_WORK = 6'h1C; // 01 1100
  localparam logic [5:0] OP_ADD_WORK_FILE = 6'h07; // 00 0111
  localparam logic [5:0] OP_AND_LIT_WORK = 6'h1B; // 01 1011
  localparam logic [5:0] OP_AND_WORK_FILE = 6'h05; // 00 0101
  localparam logic [4:0] OP_CLR_FILE_BIT = 5'h08;  // 01 000
  localparam logic [4:0] OP_SET_FILE_BIT = 5'h09;  // 01 001

  // field positions
  localparam int unsigned OP6_LSB  = 8;
  localparam int unsigned OP5_LSB  = 9;
  localparam int unsigned DEST_BIT = 7;
  localparam int unsigned BIDX_LSB = 6;

  localparam logic       DEST_WORK = 1'b0;
  localparam logic       DEST_FILE = 1'b1;
  localparam int unsigned HALF_W   = 4;

  // reset values
  localparam logic [7:0] WORK_RST = 8'h00;

  typedef enum logic [2:0] {
    ABX_OP_NONE,
    ABX_OP_ADD_LIT,
    ABX_OP_ADD_FILE,
    ABX_OP_AND_LIT,
    ABX_OP_AND_FILE,
    ABX_OP_CLR_BIT,
    ABX_OP_SET_BIT
  } abx_op_t;

  typedef struct packed {
    logic       carry;
    logic       decimal_carry_flag;
    logic       zero;
  } abx_flags_t;

  typedef struct packed {
    logic       wr_en;
    logic [6:0] addr;
    logic [7:0] data;
  } abx_file_wr_t;

  typedef struct packed {
    logic [7:0]   work;
    abx_flags_t   flags;
    abx_file_wr_t file_wr;
    logic         done;
    logic         unknown;
  } abx_state_t;

endpackage

/* File: rtl/abx_execute.sv */
// abx_execute: single-cycle execute stage for add, and, bit clear and bit set
// assumes the fetch side presents the word with the file operand already read
//
// Overview of operation
// RQ1: literal add sums the literal and work, writes work, updates carry, decimal carry and zero, in one cycle.
// RQ2: work-and-file add sums work and the file byte, routes it to the destination, updates all three flags, in one cycle.
// RQ3: destination bit 0 writes work and leaves the file alone; 1 writes the addressed file register.
// RQ4: literal and writes the bitwise and of literal and work into work, touching only zero, in one cycle.
// RQ5: work-and-file and routes the bitwise and to the destination, touching only zero, in one cycle.
// RQ6: bit clear forces the indexed bit of the file byte to 0, keeping other bits and all flags, in one cycle.
// RQ7: bit set forces the indexed bit of the file byte to 1, keeping other bits and all flags, in one cycle.
// RQ8: byte operations take a seven-bit file address 00h..7Fh and one destination bit.
// RQ9: bit operations take a six-bit file address 00h..3Fh and a bit index 0..7.
// RQ10: zero means an all-zero result; carry is out of bit 7 and decimal carry out of bit 3 on addition.
// RQ11: sums are cut to eight bits before writing; overflow shows only in carry.
`timescale 1ns/100ps
module abx_execute
  import abx_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              insn_valid,
  input  wire logic [INSN_W-1:0] insn,
  input  wire logic [7:0]        file_rd_data,
  output abx_flags_t             flags,
  output logic [7:0]             work,
  output abx_file_wr_t           file_wr,
  output logic [6:0]             file_rd_addr,
  output logic                   done,
  output logic                   unknown_op
);

  abx_state_t s_q;
  abx_state_t s_d;
  logic [6:0] rd_addr_q;
  logic [6:0] rd_addr_d;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  abx_op_t            op;
  logic [DATA_W-1:0]  lit;
  logic [FADDR_W-1:0] faddr;
  logic [BADDR_W-1:0] baddr;
  logic [BIDX_W-1:0]  bidx;
  logic               dest;

  always_comb begin
    lit   = insn[DATA_W-1:0];
    faddr = insn[FADDR_W-1:0];                        // RQ8
    baddr = insn[BADDR_W-1:0];                        // RQ9
    bidx  = insn[BIDX_LSB +: BIDX_W];                 // RQ9
    dest  = insn[DEST_BIT];                           // RQ8
    op    = ABX_OP_NONE;
    if (insn[INSN_W-1:OP6_LSB] == OP_ADD_LIT_WORK) begin
      op = ABX_OP_ADD_LIT;
    end else if (insn[INSN_W-1:OP6_LSB] == OP_ADD_WORK_FILE) begin
      op = ABX_OP_ADD_FILE;
    end else if (insn[INSN_W-1:OP6_LSB] == OP_AND_LIT_WORK) begin
      op = ABX_OP_AND_LIT;
    end else if (insn[INSN_W-1:OP6_LSB] == OP_AND_WORK_FILE) begin
      op = ABX_OP_AND_FILE;
    end else if (insn[INSN_W-1:OP5_LSB] == OP_CLR_FILE_BIT) begin
      op = ABX_OP_CLR_BIT;
    end else if (insn[INSN_W-1:OP5_LSB] == OP_SET_FILE_BIT) begin
      op = ABX_OP_SET_BIT;
    end
  end

  // file operand address for the read port, decoded here and registered onto file_rd_addr
  always_comb begin
    rd_addr_d = faddr;
    if (op == ABX_OP_CLR_BIT || op == ABX_OP_SET_BIT) begin
      rd_addr_d = {1'b0, baddr};                      // RQ9
    end
  end

  // ----------------------------------------
  // arithmetic
  // ----------------------------------------
  logic [DATA_W-1:0] add_b;
  logic [DATA_W:0]   sum;
  logic [HALF_W:0]   half_sum;
  logic [DATA_W-1:0] and_res;
  logic [DATA_W-1:0] bit_mask;

  always_comb begin
    add_b    = (op == ABX_OP_ADD_LIT) ? lit : file_rd_data;
    sum      = {1'b0, s_q.work} + {1'b0, add_b};                       // RQ10
    half_sum = {1'b0, s_q.work[HALF_W-1:0]} + {1'b0, add_b[HALF_W-1:0]}; // RQ10
    and_res  = s_q.work & ((op == ABX_OP_AND_LIT) ? lit : file_rd_data);
    bit_mask = DATA_W'(1) << bidx;
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_d              = s_q;
    s_d.file_wr      = '0;
    s_d.done         = 1'b0;
    s_d.unknown      = 1'b0;
    if (insn_valid) begin
      s_d.done = 1'b1;                                // RQ1 RQ2 RQ4 RQ5 RQ6 RQ7
      unique case (op)
        ABX_OP_ADD_LIT: begin
          s_d.work                     = sum[DATA_W-1:0]; // RQ1 RQ11
          s_d.flags.carry              = sum[DATA_W];     // RQ1
          s_d.flags.decimal_carry_flag = half_sum[HALF_W];
          s_d.flags.zero               = (sum[DATA_W-1:0] == '0); // RQ10
        end
        ABX_OP_ADD_FILE: begin
          s_d.flags.carry              = sum[DATA_W];     // RQ2
          s_d.flags.decimal_carry_flag = half_sum[HALF_W];
          s_d.flags.zero               = (sum[DATA_W-1:0] == '0);
          if (dest == DEST_WORK) begin
            s_d.work = sum[DATA_W-1:0];                   // RQ3 RQ11
          end else begin
            s_d.file_wr = '{wr_en: 1'b1, addr: faddr, data: sum[DATA_W-1:0]}; // RQ3
          end
        end
        ABX_OP_AND_LIT: begin
          s_d.work       = and_res;                       // RQ4
          s_d.flags.zero = (and_res == '0);
        end
        ABX_OP_AND_FILE: begin
          s_d.flags.zero = (and_res == '0);               // RQ5
          if (dest == DEST_WORK) begin
            s_d.work = and_res;                           // RQ3
          end else begin
            s_d.file_wr = '{wr_en: 1'b1, addr: faddr, data: and_res}; // RQ3
          end
        end
        ABX_OP_CLR_BIT: begin
          s_d.file_wr = '{wr_en: 1'b1, addr: {1'b0, baddr}, data: file_rd_data & ~bit_mask}; // RQ6
        end
        ABX_OP_SET_BIT: begin
          s_d.file_wr = '{wr_en: 1'b1, addr: {1'b0, baddr}, data: file_rd_data | bit_mask}; // RQ7
        end
        ABX_OP_NONE: begin
          s_d.done    = 1'b0;
          s_d.unknown = 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q       <= '{work: WORK_RST, flags: '0, file_wr: '0, done: 1'b0, unknown: 1'b0};
      rd_addr_q <= '0;
    end else begin
      s_q       <= s_d;
      rd_addr_q <= rd_addr_d;
    end
  end

  assign work         = s_q.work;
  assign flags        = s_q.flags;
  assign file_wr      = s_q.file_wr;
  assign done         = s_q.done;
  assign unknown_op   = s_q.unknown;
  assign file_rd_addr = rd_addr_q;

endmodule

/* File: testbench/abx_execute_properties.sv */
// checker for the execute stage
// assumes the ports of abx_execute, one clock
`timescale 1ns/100ps
module abx_execute_properties
  import abx_pkg::*;
(
  input wire logic              clk,
  input wire logic              reset_n,
  input wire logic              insn_valid,
  input wire logic [INSN_W-1:0] insn,
  input wire logic [7:0]        file_rd_data,
  input wire abx_flags_t        flags,
  input wire logic [7:0]        work,
  input wire abx_file_wr_t      file_wr,
  input wire logic [6:0]        file_rd_addr,
  input wire logic              done,
  input wire logic              unknown_op
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic known;
  assign known = insn[13:8] inside {OP_ADD_LIT_WORK, OP_ADD_WORK_FILE, OP_AND_LIT_WORK, OP_AND_WORK_FILE}
                 || insn[13:10] == 4'h4;
  sequence s_go(logic [5:0] o);
    insn_valid && insn[13:8] == o;
  endsequence
  a_add_lit: assert property (s_go(OP_ADD_LIT_WORK) |=> {flags.carry, work} ==
    9'($past(work)) + 9'($past(insn[7:0])) && flags.zero == (work == 8'h00) && flags.decimal_carry_flag ==
    (5'($past(work[3:0])) + 5'($past(insn[3:0])) > 5'h0f)) else $error("literal add wrong");
  a_add_file: assert property (s_go(OP_ADD_WORK_FILE) ##0 insn[7] |=> work == $past(work) &&
    file_wr == {1'b1, $past(insn[6:0]), 8'($past(work) + $past(file_rd_data))} &&
    flags.zero == (file_wr.data == 8'h00)) else $error("file add wrong");
  a_dest_work: assert property ((s_go(OP_ADD_WORK_FILE) or s_go(OP_AND_WORK_FILE)) ##0 !insn[7]
    |=> !file_wr.wr_en) else $error("file written for work destination");
  a_and_lit: assert property (s_go(OP_AND_LIT_WORK) |=> work == ($past(work) & $past(insn[7:0])) &&
    flags.carry == $past(flags.carry) && flags.zero == (work == 8'h00)) else $error("literal and wrong");
  a_and_file: assert property (s_go(OP_AND_WORK_FILE) |=> ($past(insn[7]) ? file_wr.data : work) ==
    ($past(work) & $past(file_rd_data)) && flags.carry == $past(flags.carry)) else $error("file and wrong");
  a_bit_clr: assert property (insn_valid && insn[13:9] == OP_CLR_FILE_BIT |=> flags == $past(flags) &&
    file_wr == {2'b10, $past(insn[5:0]), $past(file_rd_data) & ~(8'h01 << $past(insn[8:6]))})
    else $error("bit clear wrong");
  a_bit_set: assert property (insn_valid && insn[13:9] == OP_SET_FILE_BIT |=> flags == $past(flags) &&
    file_wr == {2'b10, $past(insn[5:0]), $past(file_rd_data) | (8'h01 << $past(insn[8:6]))})
    else $error("bit set wrong");
  a_done_pulse: assert property (insn_valid && known |=> done && !unknown_op) else $error("done missing");
  a_unknown_op: assert property (insn_valid && !known |=> unknown_op && !done && work == $past(work))
    else $error("unknown opcode not refused");
endmodule
bind abx_execute abx_execute_properties abx_execute_properties_i (.clk, .reset_n, .insn_valid, .insn,
  .file_rd_data, .flags, .work, .file_wr, .file_rd_addr, .done, .unknown_op);

/* File: testbench/abx_regfile_model.sv */
// register file beside the execute stage
// assumes reads answer in the cycle of the instruction
`timescale 1ns/100ps
module abx_regfile_model
  import abx_pkg::*;
(
  input  wire logic              clk,
  input  wire logic [INSN_W-1:0] insn,
  input  wire abx_file_wr_t      file_wr,
  output logic [7:0]             rd_data
);
  logic [7:0] mem [128];
  initial foreach (mem[i]) mem[i] = 8'(i) ^ 8'hA5;
  // bit ops carry a six-bit address
  assign rd_data = mem[insn[12] ? {1'b0, insn[5:0]} : insn[6:0]];
  always @(posedge clk) if (file_wr.wr_en) mem[file_wr.addr] <= file_wr.data;
endmodule

/* File: testbench/abx_execute_tb_top.sv */
// self-checking bench for the execute stage
// assumes the register file model and the bound checker
`timescale 1ns/100ps
module abx_execute_tb_top
  import abx_pkg::*;
;
  logic              clk = 0, reset_n = 0, insn_valid = 0;
  logic [INSN_W-1:0] insn = '0;
  logic [7:0]        rd, v, u;
  abx_flags_t        flags;
  logic [7:0]        work;
  abx_file_wr_t      file_wr;
  logic [6:0]        rd_addr;
  logic              done, unknown_op;
  int                n_errors = 0, samples_checked = 0;
  always #2 clk = ~clk;
  abx_execute abx_execute_i (.clk, .reset_n, .insn_valid, .insn, .file_rd_data(rd), .flags, .work, .file_wr,
    .file_rd_addr(rd_addr), .done(done), .unknown_op(unknown_op));
  abx_regfile_model abx_regfile_model_i (.clk, .insn, .file_wr, .rd_data(rd));
  task automatic close_out;
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      n_errors++;
    end
  endtask
  task automatic exe(logic [INSN_W-1:0] w);
    insn = w;
    insn_valid = 1'b1;
    @(posedge clk);
    #1;
  endtask
  task automatic t_add_lit;
    exe({OP_ADD_LIT_WORK, 8'h10});
    exe({OP_ADD_LIT_WORK, 8'h15});
    chk({done, flags, work}, {1'b1, 3'h0, 8'h25});
    exe({OP_ADD_LIT_WORK, 8'hDB});
    chk({flags, work}, {3'h7, 8'h00});
  endtask
  task automatic t_byte;
    abx_regfile_model_i.mem[7'h07] = 8'hC2;
    abx_regfile_model_i.mem[7'h7F] = 8'h01;
    exe({OP_AND_LIT_WORK, 8'h00});
    chk(flags, 3'h7);
    exe({OP_ADD_LIT_WORK, 8'h17});
    exe({OP_ADD_WORK_FILE, 8'h07});
    chk({file_wr.wr_en, work}, {1'b0, 8'hD9});
    exe({OP_ADD_WORK_FILE, 8'hFF});
    chk({file_wr, work}, {1'b1, 7'h7F, 8'hDA, 8'hD9});
    exe({OP_AND_WORK_FILE, 8'h87});
    chk({file_wr, flags}, {1'b1, 7'h07, 8'hC0, 3'h0});
    exe({OP_AND_LIT_WORK, 8'h5F});
    chk(work, 8'h59);
    exe({OP_AND_WORK_FILE, 8'h11});
    chk({done, file_wr.wr_en, flags, work}, {1'b1, 1'b0, 3'h0, 8'h10});
  endtask
  task automatic t_bits;
    v = 8'hC7;
    u = 8'h0A;
    abx_regfile_model_i.mem[7'h3F] = v;
    abx_regfile_model_i.mem[7'h00] = u;
    for (int b = 0; b < 8; b++) begin
      exe({OP_CLR_FILE_BIT, 3'(b), 6'h3F});
      v[b] = 1'b0;
      chk({rd_addr, file_wr, flags}, {7'h3F, 1'b1, 7'h3F, v, 3'h0});
      exe({OP_SET_FILE_BIT, 3'(b), 6'h00});
      u[b] = 1'b1;
      chk({rd_addr, file_wr, work}, {7'h00, 1'b1, 7'h00, u, 8'h10});
    end
  endtask
  initial begin
    repeat (2) @(posedge clk);
    #1 reset_n = 1'b1;
    chk(work, 8'h00);
    t_add_lit;
    t_byte;
    t_bits;
    exe(14'h3FFF);
    chk({unknown_op, done, file_wr.wr_en, work}, {1'b1, 1'b0, 1'b0, 8'h10});
    insn_valid = 1'b0;
    @(posedge clk);
    close_out;
  end
  initial begin
    #4000;
    n_errors++;
    close_out;
  end
endmodule
